// File: src/light_prox_regs.sv
`timescale 1ns/1ps
`include "lp_map.svh"
module light_prox_regs (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst, // sync reset, active high
    input wire logic scl, // serial bus clock
    input wire logic sda_in, // serial bus data in
    output logic sda_out, // serial data drive value
    output logic sda_oe_n, // low while pulling data low
    input wire logic [15:0] ambient_result, // new ambient result
    input wire logic ambient_valid, // ambient result strobe
    input wire logic [15:0] prox_result, // new proximity result
    input wire logic prox_valid, // proximity result strobe
    input wire logic prox_active, // proximity measurement running
    output logic ir_drive, // emitter square wave
    output logic demod_phase, // delayed reference for detection
    output logic eval_enable // receiver evaluation window
);
    // ----------------------------------------
    // bus front end
    // ----------------------------------------
    lp_pkg::bus_ev_t ev;
    logic [7:0] rd_data;

    serial_byte_slave u_slave (
        .core_clk(core_clk),
        .rst(rst),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rd_data(rd_data),
        .ev(ev)
    );

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] ptr;
    logic [15:0] ambient;
    logic [15:0] prox;
    lp_pkg::mod_cfg_t cfg;

    function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [15:0] amb,
                                            input logic [15:0] prx, input lp_pkg::mod_cfg_t c);
        logic [7:0] r;
        r = 8'h00;
        if (addr == `REG_AMB_HI) begin
            r = amb[15:8];
        end else if (addr == `REG_AMB_LO) begin
            r = amb[7:0];
        end else if (addr == `REG_PROX_HI) begin
            r = prx[15:8];
        end else if (addr == `REG_PROX_LO) begin
            r = prx[7:0];
        end else if (addr == `REG_FREQ) begin
            r[`FREQ_MSB:`FREQ_LSB] = c.freq;
        end else if (addr == `REG_TIMING) begin
            r[`DELAY_MSB:`DELAY_LSB] = c.delay;
            r[`DEAD_MSB:`DEAD_LSB] = c.dead;
        end
        return r;
    endfunction

    assign rd_data = read_mux(ptr, ambient, prox, cfg);

    wire data_wr = ev.wr & ~ev.first;
    wire wr_freq = data_wr && ptr == `REG_FREQ;
    wire wr_timing = data_wr && ptr == `REG_TIMING;
    wire [7:0] next_ptr = ev.first ? ev.data : ptr + 8'h01;
    wire ptr_step = ev.wr | ev.rd_done;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptr <= `PTR_RESET;
        end else if (ptr_step) begin
            ptr <= next_ptr;
        end
    end

    // results change only on measurement strobes; bus writes never reach them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ambient <= `RESULT_RESET;
            prox <= `RESULT_RESET;
        end else begin
            if (ambient_valid) begin
                ambient <= ambient_result;
            end
            if (prox_valid) begin
                prox <= prox_result;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg.freq <= `FREQ_RESET;
            cfg.delay <= `DELAY_RESET;
            cfg.dead <= `DEAD_RESET;
        end else begin
            if (wr_freq) begin
                cfg.freq <= ev.data[`FREQ_MSB:`FREQ_LSB];
            end
            if (wr_timing) begin
                cfg.delay <= ev.data[`DELAY_MSB:`DELAY_LSB];
                cfg.dead <= ev.data[`DEAD_MSB:`DEAD_LSB];
            end
        end
    end

    // ----------------------------------------
    // modulator
    // ----------------------------------------
    // half period of the fastest rate; each code step doubles it
    localparam int HALF_BASE_I = `CLK_KHZ / (2 * `TEST_FREQ_MAX_KHZ);
    localparam logic [7:0] HALF_BASE = HALF_BASE_I[7:0];

    logic [7:0] phase_cnt;
    logic [6:0] ir_hist;
    wire [7:0] half_len = HALF_BASE << cfg.freq;
    wire phase_end = phase_cnt == half_len - 8'h01;
    wire [7:0] next_phase = phase_end ? 8'h00 : phase_cnt + 8'h01;
    wire next_ir = phase_end ? ~ir_drive : ir_drive;
    // tap k is the emitter level k cycles back; history starts low, so the
    // reference cannot rise before the first delayed edge after activation
    wire [7:0] ir_taps = {ir_hist, next_ir};
    wire [7:0] delay_ext = {5'h00, cfg.delay};
    wire [7:0] dead_ext = {5'h00, cfg.dead};
    wire before_delay = next_phase < delay_ext;
    // position relative to the delayed edge, wrapped into one half period
    wire [7:0] rel_pos = before_delay ? next_phase + half_len - delay_ext : next_phase - delay_ext;
    wire in_window = rel_pos >= dead_ext && rel_pos < half_len - dead_ext;

    always_ff @(posedge core_clk) begin
        if (rst || !prox_active) begin
            phase_cnt <= 8'h00;
            ir_hist <= 7'h00;
            ir_drive <= 1'b0;
            demod_phase <= 1'b0;
            eval_enable <= 1'b0;
        end else begin
            phase_cnt <= next_phase;
            ir_hist <= ir_taps[6:0];
            ir_drive <= next_ir;
            demod_phase <= ir_taps[cfg.delay];
            eval_enable <= in_window;
        end
    end
endmodule // light_prox_regs

// File: src/lp_map.svh
// What this block does
// - ambient result bytes at 85h, 86h
// - ambient result bytes read-only, writes ignored
// - proximity result bytes at 87h, 88h
// - proximity bytes read-only, high byte first
// - frequency field selects test-signal rate
// - frequency field resets to code 10
// - emitter square wave, evaluate against it
// - delay field shifts evaluation after edges
// - dead-time field blanks evaluation around edges
// - pointer loads from the first written byte, advances after every later byte
`ifndef LP_MAP_SVH
`define LP_MAP_SVH

// ----------------------------------------
// bus address and register offsets
// ----------------------------------------
`define DEV_ADDR 7'h13
`define REG_AMB_HI 8'h85
`define REG_AMB_LO 8'h86
`define REG_PROX_HI 8'h87
`define REG_PROX_LO 8'h88
`define REG_FREQ 8'h89
`define REG_TIMING 8'h8a

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FREQ_MSB 1
`define FREQ_LSB 0
`define DELAY_MSB 7
`define DELAY_LSB 5
`define DEAD_MSB 2
`define DEAD_LSB 0
`define FREQ_RESET 2'h2
`define DELAY_RESET 3'h0
`define DEAD_RESET 3'h0
`define RESULT_RESET 16'h0000
`define PTR_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ 100000
`define TEST_FREQ_MAX_KHZ 3125

`endif

// File: src/lp_pkg.sv
package lp_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_ACK_A = 7'b0000100,
        ST_RX = 7'b0001000,
        ST_ACK_W = 7'b0010000,
        ST_TX = 7'b0100000,
        ST_ACK_R = 7'b1000000
    } slave_state_t;

    typedef struct packed {
        logic wr;
        logic first;
        logic rd_done;
        logic [7:0] data;
    } bus_ev_t;

    typedef struct packed {
        logic [2:0] delay;
        logic [2:0] dead;
        logic [1:0] freq;
    } mod_cfg_t;

endpackage

// File: src/serial_byte_slave.sv
`timescale 1ns/1ps
`include "lp_map.svh"
module serial_byte_slave (
    input wire logic core_clk, // system clock
    input wire logic rst, // sync reset
    input wire logic scl, // bus clock level
    input wire logic sda_in, // bus data level
    output logic sda_out, // data drive value
    output logic sda_oe_n, // low while pulling data low
    input wire logic [7:0] rd_data, // byte at pointer
    output lp_pkg::bus_ev_t ev // one-cycle bus events
);
    lp_pkg::slave_state_t state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;

    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_cond = scl & scl_q & sda_q & ~sda_in;
    wire stop_cond = scl & scl_q & ~sda_q & sda_in;
    wire [7:0] shifted = {shreg[6:0], sda_in};
    wire addr_hit = shreg[7:1] == `DEV_ADDR;

    always_ff @(posedge core_clk) begin
        scl_q <= scl;
        sda_q <= sda_in;
        ev <= '0;
        sda_out <= 1'b0;
        if (rst) begin
            state <= lp_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
        end else if (start_cond) begin
            state <= lp_pkg::ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (stop_cond) begin
            state <= lp_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                lp_pkg::ST_ADDR, lp_pkg::ST_RX: begin
                    if (scl_rise && bitcnt != 4'h8) begin
                        shreg <= shifted;
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (state == lp_pkg::ST_RX) begin
                            ev.wr <= 1'b1;
                            ev.first <= first;
                            ev.data <= shreg;
                            first <= 1'b0;
                            sda_oe_n <= 1'b0;
                            state <= lp_pkg::ST_ACK_W;
                        end else if (addr_hit) begin
                            rw <= shreg[0];
                            sda_oe_n <= 1'b0;
                            state <= lp_pkg::ST_ACK_A;
                        end else begin
                            state <= lp_pkg::ST_IDLE;
                        end
                    end
                end
                lp_pkg::ST_ACK_A, lp_pkg::ST_ACK_W: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        if (state == lp_pkg::ST_ACK_A && rw) begin
                            shreg <= rd_data;
                            sda_oe_n <= rd_data[7];
                            state <= lp_pkg::ST_TX;
                        end else begin
                            first <= state == lp_pkg::ST_ACK_A;
                            sda_oe_n <= 1'b1;
                            state <= lp_pkg::ST_RX;
                        end
                    end
                end
                lp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            ev.rd_done <= 1'b1;
                            sda_oe_n <= 1'b1;
                            state <= lp_pkg::ST_ACK_R;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe_n <= shreg[6];
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                lp_pkg::ST_ACK_R: begin
                    // a nack ends the read; only a new start revives the slave
                    if (scl_rise && sda_in) begin
                        state <= lp_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        bitcnt <= 4'h0;
                        shreg <= rd_data;
                        sda_oe_n <= rd_data[7];
                        state <= lp_pkg::ST_TX;
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end
endmodule // serial_byte_slave

// File: verif/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic core_clk, // clock
    input wire logic sda_oe_n, // device pull, low active
    output logic scl, // bus clock
    output logic sda_in // resolved data line
);
logic sda_h;
assign sda_in = sda_h & sda_oe_n; // pull-up: a released line reads 1
initial begin
    scl = 1'b1;
    sda_h = 1'b1;
end
// quarter bit of 8 clocks keeps well above the 4 per phase minimum
task automatic q();
    repeat (8) @(posedge core_clk);
    #1;
endtask
task automatic start();
    sda_h = 1'b1; q(); scl = 1'b1; q(); sda_h = 1'b0; q(); scl = 1'b0; q();
endtask
task automatic stop();
    sda_h = 1'b0; q(); scl = 1'b1; q(); sda_h = 1'b1; q();
endtask
task automatic bitx(input logic b, output logic r);
    sda_h = b; q(); scl = 1'b1; q(); r = sda_in; q(); scl = 1'b0; q();
endtask
task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
endtask
task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
endtask
endmodule // i2c_host_model

// File: verif/light_prox_chk.sv
`timescale 1ns/1ps
module light_prox_chk (
    input wire logic core_clk, // clock
    input wire logic rst, // sync reset
    input wire logic scl, // bus clock
    input wire logic sda_oe_n, // data pull, low active
    input wire logic prox_active, // measurement on
    input wire logic ir_drive, // emitter wave
    input wire logic demod_phase, // delayed reference
    input wire logic eval_enable // evaluation window
);
// ------------------------------
// length of the current ir level
// ------------------------------
logic ir_q;
logic [7:0] run;
always_ff @(posedge core_clk) begin
    ir_q <= ir_drive;
    if (rst) begin
        run <= 8'h00;
    end else if (ir_drive != ir_q) begin
        run <= 8'h01;
    end else if (run != 8'hff) begin
        run <= run + 8'h01;
    end
end
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
sequence s_start; $rose(prox_active); endsequence
sequence s_ir_fall; $fell(ir_drive) && $past(prox_active) && prox_active; endsequence
property p_idle_quiet; !prox_active |=> !ir_drive && !demod_phase && !eval_enable; endproperty
property p_half_len; s_ir_fall |-> run inside {8'h10, 8'h20, 8'h40, 8'h80}; endproperty
property p_start_low; s_start |=> !ir_drive [*8]; endproperty
// delay field tops out at 7, so the reference trails ir by at most 7 cycles
property p_demod_follow;
    $changed(demod_phase) && prox_active && $past(prox_active) |-> (ir_drive != ir_q) || (run <= 8'h08);
endproperty
property p_demod_in_ir; $rose(demod_phase) |-> ir_drive; endproperty
property p_eval_active; eval_enable |-> $past(prox_active); endproperty
property p_oe_scl_low; $changed(sda_oe_n) |-> !scl; endproperty
property p_oe_hold; $fell(sda_oe_n) |=> !sda_oe_n [*4]; endproperty
a_idle_quiet: assert property (p_idle_quiet) else $error("modulator active while idle");
a_half_len: assert property (p_half_len) else $error("bad ir half period");
a_start_low: assert property (p_start_low) else $error("ir toggled too early");
a_demod_follow: assert property (p_demod_follow) else $error("reference not tied to ir");
a_demod_in_ir: assert property (p_demod_in_ir) else $error("reference rose while ir low");
a_eval_active: assert property (p_eval_active) else $error("evaluation while idle");
a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
a_oe_hold: assert property (p_oe_hold) else $error("data pull too short");
endmodule // light_prox_chk
bind light_prox_regs light_prox_chk i_chk (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_oe_n(sda_oe_n), .prox_active(prox_active),
    .ir_drive(ir_drive), .demod_phase(demod_phase), .eval_enable(eval_enable));

// File: verif/light_prox_regs_bench.sv
`timescale 1ns/1ps
module light_prox_regs_bench;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic scl, sda_in, sda_out, sda_oe_n, ir_drive, demod_phase, eval_enable;
logic k_bad;
logic [15:0] ambient_result = 16'h0000;
logic [15:0] prox_result = 16'h0000;
logic ambient_valid = 1'b0;
logic prox_valid = 1'b0;
logic prox_active = 1'b0;
integer n_mismatch = 0;
integer cmp_count = 0;
integer seed = 32'h04b57931;
integer amb = 0, prx = 0, freq = 2, tim = 0;
always #5 core_clk = ~core_clk;
light_prox_regs i_light_prox_regs (.core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .ambient_result(ambient_result), .ambient_valid(ambient_valid),
    .prox_result(prox_result), .prox_valid(prox_valid), .prox_active(prox_active),
    .ir_drive(ir_drive), .demod_phase(demod_phase), .eval_enable(eval_enable));
i2c_host_model i_host (.core_clk(core_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
// ------------------------------
// reference model and helpers
// ------------------------------
function automatic logic [7:0] mdl(input int a);
    case (a)
        'h85: return amb[15:8];
        'h86: return amb[7:0];
        'h87: return prx[15:8];
        'h88: return prx[7:0];
        'h89: return freq[7:0];
        'h8a: return tim[7:0];
        default: return 8'h00;
    endcase
endfunction
task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic wb(input logic [7:0] d);
    logic k;
    i_host.wbyte(d, k);
    chk({15'h0, k}, 16'h0001);
    chk({15'h0, sda_out}, 16'h0000);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.start(); wb(8'h26); wb(a); wb(d); i_host.stop();
endtask
task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d;
    i_host.start(); wb(8'h26); wb(a); i_host.start(); wb(8'h27);
    for (int i = 0; i < n; i++) begin
        i_host.rbyte(i == n - 1, d);
        chk({8'h00, d}, {8'h00, mdl(a + i)});
    end
    i_host.stop();
endtask
task automatic load();
    integer r;
    r = $random(seed);
    ambient_result = r[15:0]; prox_result = r[31:16];
    ambient_valid = 1'b1; prox_valid = 1'b1;
    amb = r & 'hffff; prx = (r >> 16) & 'hffff;
    @(posedge core_clk); #1;
    ambient_valid = 1'b0; prox_valid = 1'b0;
endtask
// one full ir period sampled from its rising edge
task automatic meas(input int h);
    int n, hi, ev, lag;
    n = 0; hi = 0; ev = 0; lag = -1;
    prox_active = 1'b1;
    while (ir_drive !== 1'b1 && n < 400) begin
        @(posedge core_clk); #1; n++;
    end
    if (n == 400) begin
        n_mismatch++;
        $display("BAD %0t ir never rose", $time);
    end else begin
        for (n = 0; n < 2 * h; n++) begin
            if (ir_drive === 1'b1) hi++;
            if (eval_enable === 1'b1) ev++;
            if (demod_phase === 1'b1 && lag < 0) lag = n;
            @(posedge core_clk); #1;
        end
        chk(16'(hi), 16'(h));
        chk(16'(lag), 16'h0004);
        chk(16'(ev), 16'(2 * h - 4));
    end
    prox_active = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
endtask
initial begin
    repeat (2) @(posedge core_clk);
    #1; rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rd(8'h84, 8);
    $display("test 1 done");
    repeat (4) begin
        load();
        rd(8'h85, 4);
    end
    $display("test 2 done");
    for (int a = 'h85; a <= 'h88; a++) wr(8'(a), 8'($random(seed)));
    wr(8'h89, 8'hff); freq = 3;
    wr(8'h8a, 8'hff); tim = 'he7;
    i_host.start();
    i_host.wbyte(8'h28, k_bad);
    i_host.stop();
    chk({15'h0, k_bad}, 16'h0000);
    rd(8'h85, 6);
    $display("test 3 done");
    for (int f = 0; f < 4; f++) begin
        wr(8'h89, 8'(f)); freq = f;
        wr(8'h8a, 8'd129); tim = 129;
        rd(8'h89, 2);
        meas(16 << f);
    end
    $display("test 4 done");
    stop_test();
end
endmodule // light_prox_regs_bench
